// ### hw/ubr_uart.sv
`timescale 1ns/100ps
`default_nettype none
`include "ubr_params.svh"
// Functional notes
// - Break frame: start bit, twelve zeros, one stop bit.
// - Transmit write with break and enable set starts break; data ignored.
// - Break bit self-clears after stop; queued character then follows.
// - Break starts only from idle, ahead of queued characters, and raises no transmit flag.
// - Shift-empty flag tracks shift register during break as usual.
// - Recovery at 16x baud with majority; shifter advances per bit.
// - After stop sample, word moves into receive FIFO if room.
// - Receive FIFO is four by nine bits; port reads oldest.
// - Fifth word with full FIFO sets overrun, word held, transfers blocked.
// - Only software clears overrun; clearing empties the receive FIFO.
// - Framing error set when stop bit sampled low.
// - Parity error reflects head word mismatch; meaningless in 9-bit mode.
// - Error flags stored with each FIFO word.
// - Receive select: 0x every transfer, 10 three or more, 11 full.
// - Receive select may change any time, no reset needed.
// - Receiver idle flag high when receive shifter empty; no interrupt.
// - Data-available flag high while FIFO holds unread word.
// - Transmit enable needs module enable; setting it raises transmit flag.
// - Transmit data write starts sending; full flag on bit 9.
// - Select 11 means 9-bit no parity; ninth bit from bit 8.
// - Module disable empties FIFOs, resets baud, clears flags except receive interrupt flag, aborts.
// - LSB first both ways, same format and rate.
module ubr_uart (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic serial_in_pin_i,
   output logic serial_out_pin_o,
   output logic tx_irq_flag_o,
   output logic rx_irq_flag_o
);
   import ubr_pkg::*;

   logic module_enable_q, stop_count_select_q;
   logic [1:0] parity_data_select_q, rx_irq_select_q, tx_irq_select_q;
   logic [15:0] baud_divisor_q, baud_cnt_q;
   logic transmit_enable_q, break_request_q, tx_irq_flag_q, rx_irq_flag_q;
   logic overrun_flag_q;
   logic tick;
   logic wr_en, rd_en, acc;
   logic [8:0] txf_mem_q [0:`UBR_FIFO_DEPTH-1];
   logic [1:0] txf_wp_q, txf_rp_q;
   logic [2:0] txf_cnt_q;
   ubr_rx_entry_t rxf_mem_q [0:`UBR_FIFO_DEPTH-1];
   logic [1:0] rxf_wp_q, rxf_rp_q;
   logic [2:0] rxf_cnt_q;
   ubr_tx_st_t tx_st_q;
   logic [3:0] tx_ovs_q, tx_bit_q;
   logic [11:0] tx_shift_q;
   logic tx_is_break_q, tx_par_q;
   ubr_rx_st_t rx_st_q;
   logic [3:0] rx_ovs_q, rx_bit_q;
   logic [8:0] rx_shift_q;
   logic rx_par_q, rx_held_q, rx_full_q, rx_framing_error_flag_q, rx_parity_error_flag_q;
   logic [2:0] maj_q;
   logic rx_line;
   logic nine_bit, par_en;
   logic txd_wr, rxd_rd, stat_wr, tx_load, tx_done, rx_push, rx_word_done;
   logic [3:0] data_bits;
   logic [31:0] rd_data;

   // Decoded modes and strobes
   assign nine_bit = (parity_data_select_q == 2'h3);
   assign par_en = (parity_data_select_q == 2'h1) || (parity_data_select_q == 2'h2);
   assign data_bits = nine_bit ? 4'd9 : 4'd8;
   assign acc = clk_en_i && psel_i && penable_i;
   assign wr_en = acc && pwrite_i;
   assign rd_en = acc && !pwrite_i;
   assign txd_wr = wr_en && (paddr_i == `UBR_TXD_OFS) && module_enable_q;
   assign rxd_rd = rd_en && (paddr_i == `UBR_RXD_OFS) && (rxf_cnt_q != 3'h0);
   assign stat_wr = wr_en && (paddr_i == `UBR_STAT_OFS);
   assign tick = module_enable_q && (baud_cnt_q == baud_divisor_q);
   // Majority of three mid-bit samples
   assign rx_line = (maj_q[0] & maj_q[1]) | (maj_q[1] & maj_q[2]) | (maj_q[0] & maj_q[2]);

   // Register read mux
   always_comb begin
      rd_data = 32'h0;
      unique case (paddr_i)
         `UBR_MODE_OFS: begin
            rd_data[`UBR_MODE_EN_BIT] = module_enable_q;
            rd_data[`UBR_MODE_PDS_LO +: 2] = parity_data_select_q;
            rd_data[`UBR_MODE_STOP_BIT] = stop_count_select_q;
         end
         `UBR_STAT_OFS: begin
            rd_data[`UBR_ST_RXDA_BIT] = (rxf_cnt_q != 3'h0);
            rd_data[`UBR_ST_OVR_BIT] = overrun_flag_q;
            rd_data[`UBR_ST_FRAMING_ERROR_FLAG_BIT] = rxf_mem_q[rxf_rp_q][9] && (rxf_cnt_q != 3'h0);
            rd_data[`UBR_ST_PARITY_ERROR_FLAG_BIT] = rxf_mem_q[rxf_rp_q][10] && (rxf_cnt_q != 3'h0);
            rd_data[`UBR_ST_RX_IDLE_FLAG_BIT] = !rx_full_q && (rx_st_q == UBR_RX_IDLE);
            rd_data[`UBR_ST_RXSEL_LO +: 2] = rx_irq_select_q;
            rd_data[`UBR_ST_TSE_BIT] = (tx_st_q == UBR_TX_IDLE);
            rd_data[`UBR_ST_TBF_BIT] = (txf_cnt_q == 3'h4);
            rd_data[`UBR_ST_TXEN_BIT] = transmit_enable_q;
            rd_data[`UBR_ST_BRK_BIT] = break_request_q;
            rd_data[`UBR_ST_TXIF_BIT] = tx_irq_flag_q;
            rd_data[`UBR_ST_RXIF_BIT] = rx_irq_flag_q;
            rd_data[15:14] = tx_irq_select_q;
         end
         `UBR_RXD_OFS: rd_data[8:0] = nine_bit ? rxf_mem_q[rxf_rp_q][8:0] :
            {1'b0, rxf_mem_q[rxf_rp_q][7:0]};
         `UBR_BAUD_OFS: rd_data[15:0] = baud_divisor_q;
         default: rd_data = 32'h0;
      endcase
   end

   // APB answer, one cycle in access phase
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         prdata_o <= 32'h0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else if (clk_en_i) begin
         pready_o <= psel_i && !pready_o;
         pslverr_o <= psel_i && !pready_o && (paddr_i > `UBR_BAUD_OFS);
         prdata_o <= rd_data;
      end
   end

   // Configuration registers; mode and baud untouched by disable
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         module_enable_q <= 1'b0;
         parity_data_select_q <= 2'h0;
         stop_count_select_q <= 1'b0;
         baud_divisor_q <= `UBR_BAUD_RST;
         rx_irq_select_q <= 2'h0;
         tx_irq_select_q <= 2'h0;
      end else if (wr_en && pready_o) begin
         if (paddr_i == `UBR_MODE_OFS) begin
            module_enable_q <= pwdata_i[`UBR_MODE_EN_BIT];
            parity_data_select_q <= pwdata_i[`UBR_MODE_PDS_LO +: 2];
            stop_count_select_q <= pwdata_i[`UBR_MODE_STOP_BIT];
         end
         if (paddr_i == `UBR_BAUD_OFS) baud_divisor_q <= pwdata_i[15:0];
         if (stat_wr) begin
            rx_irq_select_q <= pwdata_i[`UBR_ST_RXSEL_LO +: 2];
            tx_irq_select_q <= pwdata_i[15:14];
         end
      end
   end

   // Transmit control flags
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !module_enable_q) begin
         transmit_enable_q <= 1'b0;
         break_request_q <= 1'b0;
         tx_irq_flag_q <= 1'b0;
      end else if (clk_en_i) begin
         if (stat_wr && pready_o) begin
            transmit_enable_q <= pwdata_i[`UBR_ST_TXEN_BIT];
            break_request_q <= pwdata_i[`UBR_ST_BRK_BIT];
         end
         if (tx_done && tx_is_break_q) break_request_q <= 1'b0;
         if (stat_wr && pready_o && !pwdata_i[`UBR_ST_TXIF_BIT]) tx_irq_flag_q <= 1'b0;
         // Set wins over clear
         if ((stat_wr && pready_o && pwdata_i[`UBR_ST_TXEN_BIT] && !transmit_enable_q) ||
             (tx_load && tx_irq_select_q == 2'h0) ||
             (tx_load && txf_cnt_q == 3'h1 && tx_irq_select_q == 2'h1) ||
             (tx_done && !tx_is_break_q && txf_cnt_q == 3'h0 && tx_irq_select_q == 2'h2))
            tx_irq_flag_q <= 1'b1;
      end
   end

   // Baud counter
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !module_enable_q) baud_cnt_q <= 16'h0;
      else if (clk_en_i) baud_cnt_q <= tick ? 16'h0 : baud_cnt_q + 16'h1;
   end

   // Transmit FIFO; break-start write is not queued
   assign tx_load = clk_en_i && tx_st_q == UBR_TX_IDLE && txf_cnt_q != 3'h0 && transmit_enable_q &&
                    !break_request_q;
   assign tx_done = clk_en_i && tick && tx_st_q == UBR_TX_STOP && tx_ovs_q == `UBR_OVS_LAST &&
                    tx_bit_q == 4'h0;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !module_enable_q) begin
         txf_wp_q <= 2'h0;
         txf_rp_q <= 2'h0;
         txf_cnt_q <= 3'h0;
      end else if (clk_en_i) begin
         logic push;
         push = txd_wr && pready_o && txf_cnt_q != 3'h4 &&
                !(break_request_q && transmit_enable_q && tx_st_q == UBR_TX_IDLE);
         if (push) begin
            txf_mem_q[txf_wp_q] <= pwdata_i[8:0];
            txf_wp_q <= txf_wp_q + 2'h1;
         end
         if (tx_load) txf_rp_q <= txf_rp_q + 2'h1;
         txf_cnt_q <= txf_cnt_q + {2'h0, push} - {2'h0, tx_load};
      end
   end

   // Transmitter: start, data or break zeros, parity, stop
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !module_enable_q || !transmit_enable_q) begin
         tx_st_q <= UBR_TX_IDLE;
         tx_ovs_q <= 4'h0;
         tx_bit_q <= 4'h0;
         tx_shift_q <= 12'h0;
         tx_is_break_q <= 1'b0;
         tx_par_q <= 1'b0;
         serial_out_pin_o <= 1'b1;
      end else if (clk_en_i) begin
         unique case (tx_st_q)
            UBR_TX_IDLE: begin
               serial_out_pin_o <= 1'b1;
               tx_ovs_q <= 4'h0;
               if (txd_wr && pready_o && break_request_q) begin
                  tx_is_break_q <= 1'b1;
                  tx_shift_q <= 12'h0;
                  tx_bit_q <= `UBR_BRK_ZEROS;
                  tx_st_q <= UBR_TX_START;
               end else if (tx_load) begin
                  tx_is_break_q <= 1'b0;
                  tx_shift_q <= {3'h0, txf_mem_q[txf_rp_q]};
                  tx_bit_q <= data_bits + {3'h0, par_en};
                  tx_par_q <= ^txf_mem_q[txf_rp_q][7:0] ^ (parity_data_select_q == 2'h2);
                  tx_st_q <= UBR_TX_START;
               end
            end
            UBR_TX_START: if (tick) begin
               serial_out_pin_o <= 1'b0;
               tx_ovs_q <= tx_ovs_q + 4'h1;
               if (tx_ovs_q == `UBR_OVS_LAST) tx_st_q <= UBR_TX_DATA;
            end
            UBR_TX_DATA: if (tick) begin
               // LSB first; parity sent after last data bit
               if (!tx_is_break_q && par_en && tx_bit_q == 4'h1) serial_out_pin_o <= tx_par_q;
               else serial_out_pin_o <= tx_shift_q[0];
               tx_ovs_q <= tx_ovs_q + 4'h1;
               if (tx_ovs_q == `UBR_OVS_LAST) begin
                  tx_shift_q <= {1'b0, tx_shift_q[11:1]};
                  tx_bit_q <= tx_bit_q - 4'h1;
                  if (tx_bit_q == 4'h1) begin
                     tx_st_q <= UBR_TX_STOP;
                     tx_bit_q <= (stop_count_select_q && !tx_is_break_q) ? 4'h1 : 4'h0;
                  end
               end
            end
            UBR_TX_STOP: if (tick) begin
               serial_out_pin_o <= 1'b1;
               tx_ovs_q <= tx_ovs_q + 4'h1;
               if (tx_ovs_q == `UBR_OVS_LAST) begin
                  if (tx_bit_q == 4'h0) tx_st_q <= UBR_TX_IDLE;
                  else tx_bit_q <= 4'h0;
               end
            end
         endcase
      end
   end

   // Receiver: 16x recovery, shifter per bit
   assign rx_word_done = clk_en_i && tick && rx_st_q == UBR_RX_STOP && rx_ovs_q == `UBR_OVS_LAST;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !module_enable_q) begin
         rx_st_q <= UBR_RX_IDLE;
         rx_ovs_q <= 4'h0;
         rx_bit_q <= 4'h0;
         rx_shift_q <= 9'h0;
         rx_par_q <= 1'b0;
         rx_framing_error_flag_q <= 1'b0;
         rx_parity_error_flag_q <= 1'b0;
         maj_q <= 3'h7;
      end else if (clk_en_i && tick) begin
         rx_ovs_q <= rx_ovs_q + 4'h1;
         if (rx_ovs_q >= `UBR_MAJ_S0 && rx_ovs_q <= `UBR_MAJ_S2)
            maj_q <= {maj_q[1:0], serial_in_pin_i};
         unique case (rx_st_q)
            UBR_RX_IDLE: begin
               rx_ovs_q <= 4'h0;
               if (!serial_in_pin_i && !rx_full_q) rx_st_q <= UBR_RX_START;
            end
            UBR_RX_START: if (rx_ovs_q == `UBR_OVS_LAST) begin
               if (rx_line) rx_st_q <= UBR_RX_IDLE; // false start
               else begin
                  rx_st_q <= UBR_RX_DATA;
                  rx_bit_q <= 4'h0;
                  rx_shift_q <= 9'h0;
               end
            end
            UBR_RX_DATA: if (rx_ovs_q == `UBR_OVS_LAST) begin
               rx_bit_q <= rx_bit_q + 4'h1;
               if (rx_bit_q < data_bits) rx_shift_q[rx_bit_q] <= rx_line;
               else rx_par_q <= rx_line;
               if (rx_bit_q + 4'h1 == data_bits + {3'h0, par_en}) rx_st_q <= UBR_RX_STOP;
            end
            UBR_RX_STOP: if (rx_ovs_q == `UBR_OVS_LAST) begin
               rx_framing_error_flag_q <= !rx_line;
               rx_parity_error_flag_q <= par_en &&
                  (rx_par_q != (^rx_shift_q[7:0] ^ (parity_data_select_q == 2'h2)));
               rx_st_q <= UBR_RX_IDLE;
            end
         endcase
      end
   end

   // Completed-word holding and receive FIFO
   assign rx_push = clk_en_i && rx_full_q && !overrun_flag_q && rxf_cnt_q != 3'h4;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !module_enable_q) begin
         rx_full_q <= 1'b0;
         overrun_flag_q <= 1'b0;
         rxf_wp_q <= 2'h0;
         rxf_rp_q <= 2'h0;
         rxf_cnt_q <= 3'h0;
         rx_held_q <= 1'b0;
      end else if (clk_en_i) begin
         if (rx_word_done) rx_full_q <= 1'b1;
         else if (rx_push) rx_full_q <= 1'b0;
         rx_held_q <= rx_full_q;
         if (rx_push) begin
            rxf_mem_q[rxf_wp_q] <= {rx_parity_error_flag_q, rx_framing_error_flag_q, rx_shift_q};
            rxf_wp_q <= rxf_wp_q + 2'h1;
         end
         if (rxd_rd && pready_o) rxf_rp_q <= rxf_rp_q + 2'h1;
         rxf_cnt_q <= rxf_cnt_q + {2'h0, rx_push} - {2'h0, rxd_rd && pready_o};
         if (rx_full_q && rx_held_q && rxf_cnt_q == 3'h4 && !rx_push) overrun_flag_q <= 1'b1;
         if (stat_wr && pready_o && !pwdata_i[`UBR_ST_OVR_BIT] && overrun_flag_q) begin
            overrun_flag_q <= 1'b0;
            rxf_wp_q <= 2'h0;
            rxf_rp_q <= 2'h0;
            rxf_cnt_q <= 3'h0;
         end
      end
   end

   // Receive interrupt flag, set on transfer by select
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) rx_irq_flag_q <= 1'b0;
      else if (clk_en_i) begin
         if (stat_wr && pready_o && !pwdata_i[`UBR_ST_RXIF_BIT]) rx_irq_flag_q <= 1'b0;
         if (rx_push && (!rx_irq_select_q[1] ||
             (rx_irq_select_q == 2'h2 && rxf_cnt_q - {2'h0, rxd_rd && pready_o} >= 3'h2) ||
             (rx_irq_select_q == 2'h3 && rxf_cnt_q - {2'h0, rxd_rd && pready_o} == 3'h3)))
            rx_irq_flag_q <= 1'b1;
      end
   end

   // Flags out straight from flops
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_irq_flag_o <= 1'b0;
         rx_irq_flag_o <= 1'b0;
      end else if (clk_en_i) begin
         tx_irq_flag_o <= tx_irq_flag_q;
         rx_irq_flag_o <= rx_irq_flag_q;
      end
   end

   a_break_no_txif: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (((txd_wr && pready_o && break_request_q && transmit_enable_q && tx_st_q == UBR_TX_IDLE) ||
        (tx_is_break_q && tx_st_q != UBR_TX_IDLE)) && !tx_irq_flag_q && !(stat_wr && pready_o))
      |=> !tx_irq_flag_q)
      else $error("break changed tx flag");
   a_brk_clears_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (tx_done && tx_is_break_q && !(stat_wr && pready_o)) |=> !break_request_q)
      else $error("break bit not cleared");
   a_brk_zero_line: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (tx_is_break_q && tx_st_q == UBR_TX_DATA && $past(tx_st_q) == UBR_TX_DATA)
      |-> !serial_out_pin_o)
      else $error("break not low");
   a_ovr_on_full: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (clk_en_i && module_enable_q && rx_full_q && rx_held_q && rxf_cnt_q == 3'h4 &&
       !(stat_wr && pready_o)) |=> overrun_flag_q)
      else $error("overrun not flagged");
   a_fifo_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rxf_cnt_q <= 3'h4 && txf_cnt_q <= 3'h4)
      else $error("fifo count out of range");
   a_ovr_clear_empty: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (module_enable_q && clk_en_i && stat_wr && pready_o && overrun_flag_q &&
       !pwdata_i[`UBR_ST_OVR_BIT]) |=> (rxf_cnt_q == 3'h0))
      else $error("fifo not reset");
   a_rxif_full: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (rx_push && !(rxd_rd && pready_o) && rx_irq_select_q == 2'h3 && rxf_cnt_q == 3'h3)
      |=> rx_irq_flag_q)
      else $error("rx flag missed");
   a_disable_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !module_enable_q |=> (!transmit_enable_q && !overrun_flag_q && rxf_cnt_q == 3'h0))
      else $error("disable did not clear");
endmodule
`default_nettype wire

// ### shared/ubr_params.svh
`ifndef UBR_PARAMS_SVH
`define UBR_PARAMS_SVH
// Register byte offsets
`define UBR_MODE_OFS 12'h000
`define UBR_STAT_OFS 12'h004
`define UBR_TXD_OFS 12'h008
`define UBR_RXD_OFS 12'h00c
`define UBR_BAUD_OFS 12'h010
// Mode register fields
`define UBR_MODE_EN_BIT 15
`define UBR_MODE_STOP_BIT 0
`define UBR_MODE_PDS_LO 1
// Status/control register fields
`define UBR_ST_RXDA_BIT 0
`define UBR_ST_OVR_BIT 1
`define UBR_ST_FRAMING_ERROR_FLAG_BIT 2
`define UBR_ST_PARITY_ERROR_FLAG_BIT 3
`define UBR_ST_RX_IDLE_FLAG_BIT 4
`define UBR_ST_RXSEL_LO 6
`define UBR_ST_TSE_BIT 8
`define UBR_ST_TBF_BIT 9
`define UBR_ST_TXEN_BIT 10
`define UBR_ST_BRK_BIT 11
`define UBR_ST_TXIF_BIT 12
`define UBR_ST_RXIF_BIT 13
// Sizes and timing
`define UBR_FIFO_DEPTH 4
`define UBR_BRK_ZEROS 4'd12
`define UBR_OVS_LAST 4'hf
`define UBR_MAJ_S0 4'h7
`define UBR_MAJ_S2 4'h9
`define UBR_BAUD_RST 16'h0000
`endif

// ### shared/ubr_pkg.sv
`default_nettype none
package ubr_pkg;
   typedef enum logic [1:0] {UBR_TX_IDLE, UBR_TX_START, UBR_TX_DATA, UBR_TX_STOP} ubr_tx_st_t;
   typedef enum logic [1:0] {UBR_RX_IDLE, UBR_RX_START, UBR_RX_DATA, UBR_RX_STOP} ubr_rx_st_t;
   typedef logic [10:0] ubr_rx_entry_t; // {parity_error_flag, framing_error_flag, data[8:0]}
endpackage
`default_nettype wire

// ### verif/uart_break_tx_and_receiver_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ubr_params.svh"
module uart_break_tx_and_receiver_tb;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic clk_en_i = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, ser_in, ser_out, tx_flag, rx_flag;
   logic [7:0] lfsr = 8'h37;
   logic [10:0] exp_fifo[$];
   logic [10:0] held;
   logic [1:0] rxsel = 2'h0, pds = 2'h0;
   logic txen = 1'b0, ovr = 1'b0;
   int mismatches = 0, checks = 0;
   localparam logic [31:0] KEEP = 32'h1002;
   // Clock and watchdog
   initial forever #2.5 clk_i = ~clk_i;
   initial begin
      repeat (90000) @(posedge clk_i);
      mismatches++;
      give_verdict();
   end
   ubr_uart uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .serial_in_pin_i(ser_in),
      .serial_out_pin_o(ser_out), .tx_irq_flag_o(tx_flag), .rx_irq_flag_o(rx_flag));
   ubr_line_node node (.clk_i(clk_i), .line_from_dut_i(ser_out), .line_to_dut_o(ser_in));
   task automatic give_verdict();
      if (mismatches == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] expv);
      checks++;
      if (seen !== expv) begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         mismatches++;
         give_verdict();
      end
   endtask
   task automatic rdst();
      apb(1'b0, `UBR_STAT_OFS, 32'h0);
   endtask
   task automatic wstat(input logic [31:0] x);
      apb(1'b1, `UBR_STAT_OFS, x | (32'(txen) << 10) | (32'(rxsel) << 6));
   endtask
   task automatic wait_tx(input int n);
      int t;
      for (t = 0; t < 3000 && node.frames.size() < n; t++) @(posedge clk_i);
      if (t >= 3000) begin
         mismatches++;
         give_verdict();
      end
   endtask
   // Receive one random frame and update the model
   task automatic rx_frame();
      logic [8:0] d;
      logic bad, stop, pen, parity_error_flag, flag;
      lfsr = lfsr_next(lfsr);
      d = {lfsr[0] & (pds == 2'h3), lfsr};
      bad = lfsr[1] & lfsr[2];
      stop = ~(lfsr[3] & lfsr[6]);
      pen = (pds == 2'h1) || (pds == 2'h2);
      parity_error_flag = bad & pen;
      node.send(d, (pds == 2'h3) ? 9 : 8, pen, ^d[7:0] ^ pds[1] ^ bad, stop);
      if (exp_fifo.size() < `UBR_FIFO_DEPTH) begin
         exp_fifo.push_back({parity_error_flag, ~stop, d});
         case (rxsel)
            2'h2: flag = exp_fifo.size() >= 3;
            2'h3: flag = exp_fifo.size() == 4;
            default: flag = 1'b1;
         endcase
      end else begin
         held = {parity_error_flag, ~stop, d};
         flag = 1'b0;
         ovr = 1'b1;
      end
      check(rx_flag, flag);
      rdst();
      check(rd & 32'h13, (ovr ? 32'h2 : 32'h10) | (exp_fifo.size() > 0));
      wstat(KEEP);
   endtask
   // Read out every word, flags first, and compare with the model
   task automatic drain();
      logic [31:0] m;
      while (exp_fifo.size() > 0) begin
         m = (pds == 2'h3) ? 32'h1ff : 32'hff;
         rdst();
         check(rd & ((pds == 2'h3) ? 32'h5 : 32'hd), {exp_fifo[0][10:9], 2'h1} & 32'hd);
         apb(1'b0, `UBR_RXD_OFS, 32'h0);
         check(rd & m, {23'h0, exp_fifo.pop_front()} & m);
      end
      rdst();
      check(rd & 32'h1, 32'h0);
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      apb(1'b1, 12'h014, 32'hffffffff);
      apb(1'b0, 12'h014, 32'h0);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      rdst();
      check(rd & 32'h0f1f, 32'h0110);
      apb(1'b1, `UBR_MODE_OFS, 32'h8000);
      txen = 1'b1;
      wstat(KEEP);
      rdst();
      check({rd[12], tx_flag}, 2'h3);
      // Lone break: dummy data ignored, no transmit flag
      wstat(32'h802);
      apb(1'b1, `UBR_TXD_OFS, 32'hff);
      rdst();
      check(rd[8], 1'b0);
      wait_tx(1);
      check(node.frames.pop_front(), 32'h400);
      for (int i = 0; i < 10 && rd[11] !== 1'b0; i++) rdst();
      check({rd & 32'h1900, tx_flag}, {32'h0100, 1'b0});
      // Header: break then sync queued behind it
      wstat(32'h802);
      apb(1'b1, `UBR_TXD_OFS, 32'h00);
      apb(1'b1, `UBR_TXD_OFS, 32'h55);
      wait_tx(2);
      check(node.frames.pop_front(), 32'h400);
      check(node.frames.pop_front(), 32'h55);
      check(tx_flag, 1'b1);
      // Fill the transmit path until full, sixth write dropped
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `UBR_TXD_OFS, 32'h30 + i);
         if (i == 4) begin
            rdst();
            check(rd[9], 1'b1);
         end
      end
      wait_tx(5);
      for (int i = 0; i < 5; i++) check(node.frames.pop_front(), 32'h30 + i);
      // Thresholds 10 then 11, overrun on the fifth word
      rxsel = 2'h2;
      wstat(KEEP);
      for (int i = 0; i < 5; i++) begin
         if (i == 3) begin
            rxsel = 2'h3;
            wstat(KEEP);
         end
         rx_frame();
      end
      apb(1'b0, `UBR_RXD_OFS, 32'h0);
      check(rd & 32'hff, {24'h0, exp_fifo.pop_front()} & 32'hff);
      wstat(32'h1000);
      exp_fifo = {held};
      ovr = 1'b0;
      drain();
      wstat(KEEP);
      // Random formats and thresholds
      for (int i = 0; i < 12; i++) begin
         pds = lfsr[5:4];
         rxsel = lfsr[7:6];
         apb(1'b1, `UBR_MODE_OFS, 32'h8000 | (32'(pds) << 1));
         wstat(KEEP);
         repeat (lfsr[1:0] + 1) rx_frame();
         drain();
      end
      // Frozen clock enable: a whole frame goes unseen
      clk_en_i <= 1'b0;
      node.send(9'h0a5, 8, 1'b0, 1'b0, 1'b1);
      clk_en_i <= 1'b1;
      rdst();
      check(rd & 32'h11, 32'h10);
      // Disable with a word pending
      rx_frame();
      apb(1'b1, `UBR_MODE_OFS, 32'h0);
      txen = 1'b0;
      rdst();
      check(rd & 32'h0f1f, 32'h0110);
      check(node.frames.size(), 0);
      give_verdict();
   end
endmodule
`default_nettype wire

// ### verif/ubr_line_node.sv
`timescale 1ns/100ps
`default_nettype none
module ubr_line_node (
   input wire logic clk_i,
   input wire logic line_from_dut_i,
   output logic line_to_dut_o
);
   logic [31:0] frames[$];
   logic [7:0] got;
   int zeros;
   // Line idles high, as with a pull-up
   initial line_to_dut_o = 1'b1;
   // Send start, data LSB first, optional parity, stop, then one idle bit
   task automatic send(input logic [8:0] d, input int n, input logic pen, input logic par,
                       input logic stop);
      logic bits[$];
      bits.push_back(1'b0);
      for (int i = 0; i < n; i++) begin
         bits.push_back(d[i]);
      end
      if (pen) begin
         bits.push_back(par);
      end
      bits.push_back(stop);
      bits.push_back(1'b1);
      foreach (bits[i]) begin
         @(posedge clk_i);
         line_to_dut_o <= bits[i];
         repeat (15) @(posedge clk_i);
      end
   endtask
   // Decode frames as eight data bits plus a count of extra low bits
   always begin
      @(negedge line_from_dut_i);
      repeat (8) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(posedge clk_i);
         got[i] = line_from_dut_i;
      end
      zeros = 0;
      repeat (16) @(posedge clk_i);
      while (line_from_dut_i === 1'b0 && zeros < 20) begin
         zeros++;
         repeat (16) @(posedge clk_i);
      end
      frames.push_back(zeros * 256 + got);
   end
endmodule
`default_nettype wire
